/* core/fpd_core.sv */
// serial flash status word, write latch and array protection
`timescale 1ns/100ps
// Operation
// RULE_01: 512 KB, complement set: code x000 protects all, 0x1xx or 1111 none.
// RULE_02: 512 KB complement, high bit 0: lower 448/384/256 KB, or upper with b3.
// RULE_03: 512 KB complement, high bit 1: all but top (or bottom) 4 to 32 KB.
// RULE_04: 256 KB normal, high bit 0: 64 KB blocks top, b3 moves to bottom.
// RULE_05: 256 KB normal, high bit 1: top/bottom 4 to 32 KB, 000 none, 111 all.
// RULE_06: 256 KB complement, high bit 0: complement of the block mapping.
// RULE_07: 256 KB complement, high bit 1: all but top 4-32 KB; 000 all, 111 none.
// RULE_08: 256 KB complement, high bit 1, b3 set: all but bottom 4-32 KB.
// RULE_09: 16-bit status word with suspend, complement, quad, lock, select, latch, busy.
// RULE_10: busy reads 1 while program, erase or status write runs.
// RULE_11: latch shows in status; latch 0 refuses status write, program, erase.
// RULE_12: complement bit at 14, defaults 0, combines with select bits.
// RULE_13: program and erase into protected range refused; chip erase only if none.
// RULE_14: set-latch command sets latch; clear, writes, programs, erases reset it.
// RULE_15: lock bit 1 with write-protect low blocks status writes.
// RULE_16: busy and latch bits not writable; reserved bits read 0.
// RULE_17: host polls busy until 0 before next write command.
module fpd_core (
	// clock and reset
	input  wire logic                   sys_clk_i,
	input  wire logic                   rst_n_i,
	// serial pins
	input  wire logic                   sclk_i,
	input  wire logic                   cs_n_i,
	input  wire logic                   si_i,
	input  wire logic                   wp_n_i,
	output logic                        so_o,
	output logic                        so_oe_o,
	// density strap, high for the 512 KB part
	input  wire logic                   part_512k_i,
	// array operation port
	output logic                        op_start_o,
	output fpd_pkg::fpd_op_e            op_kind_o,
	output logic [fpd_pkg::AW-1:0]      op_addr_o,
	input  wire logic                   op_done_i,
	output logic                        op_suspend_o,
	output logic                        op_resume_o,
	output logic [7:0]                  prog_byte_o,
	output logic                        prog_byte_valid_o,
	// status view
	output logic [15:0]                 status_word_o,
	output logic                        quad_io_enable_o
);
	logic [4:0]               sync1;
	logic [4:0]               sync2;
	logic                     sclk_q;
	logic                     cs_q;
	logic                     part_512k;
	logic                     strap_taken;
	logic [1:0]               strap_fill;
	logic [2:0]               bitcnt;
	logic [2:0]               byteidx;
	logic [6:0]               shreg;
	logic [7:0]               opcode;
	logic [fpd_pkg::AW-1:0]   addr;
	logic [7:0]               sr_lo;
	logic [7:0]               sr_hi;
	logic                     reading;
	logic [15:0]              sr_nv;
	logic                     write_enable_latch;
	logic                     busy;
	logic                     suspended_flag;
	logic                     range_none;
	logic [fpd_pkg::DW-1:0]   range_lo;
	logic [fpd_pkg::DW-1:0]   range_hi;
	logic [fpd_pkg::DW-1:0]   tgt;
	logic [fpd_pkg::DW-1:0]   span;
	logic [fpd_pkg::DW-1:0]   reg_lo;
	logic [fpd_pkg::DW-1:0]   reg_hi;
	logic                     hit;
	logic                     rise;
	logic                     fall;
	logic                     frame_end;
	logic                     cs_n_s;
	logic                     byte_done;
	logic [7:0]               new_byte;
	logic [7:0]               rd_byte;
	logic                     ready;
	logic                     locked;
	logic                     go_set;
	logic                     go_clr;
	logic                     go_status_write_cmd;
	logic                     go_start;
	logic                     go_susp;
	logic                     go_res;
	logic                     wr_cmd;

	function automatic logic [fpd_pkg::DW-1:0] span_of(input logic [7:0] c);
		unique case (c)
			fpd_pkg::C_SECT: span_of = fpd_pkg::SPAN_SECT;
			fpd_pkg::C_B32:  span_of = fpd_pkg::SPAN_B32;
			fpd_pkg::C_B64:  span_of = fpd_pkg::SPAN_B64;
			default:         span_of = fpd_pkg::SPAN_PAGE;
		endcase
	endfunction

	function automatic fpd_pkg::fpd_op_e kind_of(input logic [7:0] c);
		unique case (c)
			fpd_pkg::C_PROG: kind_of = fpd_pkg::FPD_OP_PROG;
			fpd_pkg::C_SECT: kind_of = fpd_pkg::FPD_OP_SECT;
			fpd_pkg::C_B32:  kind_of = fpd_pkg::FPD_OP_B32;
			fpd_pkg::C_B64:  kind_of = fpd_pkg::FPD_OP_B64;
			fpd_pkg::C_WR_SR: kind_of = fpd_pkg::FPD_OP_STATUS;
			default:         kind_of = fpd_pkg::FPD_OP_CHIP;
		endcase
	endfunction

	// pin synchroniser
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1 <= fpd_pkg::SYNC_RST;
			sync2 <= fpd_pkg::SYNC_RST;
		end else begin
			sync1 <= {part_512k_i, wp_n_i, si_i, cs_n_i, sclk_i};
			sync2 <= sync1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_q <= 1'b0;
			cs_q   <= 1'b1;
		end else begin
			sclk_q <= sync2[0];
			cs_q   <= sync2[1];
		end
	end

	// density strap caught once the synchroniser holds the pin, not its reset
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			part_512k   <= 1'b0;
			strap_taken <= 1'b0;
			strap_fill  <= 2'h0;
		end else begin
			strap_fill <= {strap_fill[0], 1'b1};
			if (strap_fill[1] && !strap_taken) begin
				part_512k   <= sync2[4];
				strap_taken <= 1'b1;
			end
		end
	end

	assign cs_n_s    = sync2[1];
	assign rise      = sync2[0] && !sclk_q && !cs_n_s;
	assign fall      = !sync2[0] && sclk_q && !cs_n_s;
	assign frame_end = cs_n_s && !cs_q;
	assign byte_done = rise && (bitcnt == fpd_pkg::BIT_LAST);
	assign new_byte  = {shreg, sync2[2]};

	// command frame shifter; deselect resets it
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bitcnt  <= '0;
			byteidx <= '0;
			shreg   <= '0;
			opcode  <= '0;
			addr    <= '0;
			sr_lo   <= '0;
			sr_hi   <= '0;
			reading <= 1'b0;
		end else if (cs_n_s) begin
			bitcnt  <= '0;
			byteidx <= '0;
			reading <= 1'b0;
		end else if (rise) begin
			shreg  <= new_byte[6:0];
			bitcnt <= bitcnt + 3'h1;
			if (byte_done) begin
				if (byteidx != fpd_pkg::LEN_MAX) begin
					byteidx <= byteidx + 3'h1;
				end
				if (byteidx == 3'h0) begin
					opcode  <= new_byte;
					reading <= (new_byte == fpd_pkg::C_RD_LO) ||
						(new_byte == fpd_pkg::C_RD_HI);
				end
				if (byteidx >= 3'h1 && byteidx < fpd_pkg::LEN_ADDR) begin
					addr <= {addr[15:0], new_byte};
				end
				if (byteidx == 3'h1) begin
					sr_lo <= new_byte;
				end
				if (byteidx == 3'h2) begin
					sr_hi <= new_byte;
				end
			end
		end
	end

	// status word assembly
	always_comb begin
		status_word_o                  = sr_nv & fpd_pkg::SR_WR_MASK; // RULE_16
		status_word_o[fpd_pkg::SB_SUS]  = suspended_flag; // RULE_09
		status_word_o[fpd_pkg::SB_WEL]  = write_enable_latch; // RULE_11
		status_word_o[fpd_pkg::SB_BUSY] = busy && !suspended_flag; // RULE_10
	end
	assign quad_io_enable_o = sr_nv[fpd_pkg::SB_QE];
	assign rd_byte = (opcode == fpd_pkg::C_RD_HI) ?
		status_word_o[15:8] : status_word_o[7:0];

	// status readout, live value, msb first on the falling edge
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			so_o <= 1'b0;
		end else if (fall && reading) begin
			so_o <= rd_byte[3'h7 - bitcnt]; // RULE_09
		end
	end
	assign so_oe_o = reading && !cs_n_s;

	fpd_range u_range (
		.protect_sel_i        (sr_nv[fpd_pkg::SB_BP +: 5]),
		.protect_complement_i (sr_nv[fpd_pkg::SB_CMP]), // RULE_12
		.part_512k_i          (part_512k),
		.range_none_o         (range_none),
		.range_lo_o           (range_lo),
		.range_hi_o           (range_hi)
	); // RULE_01 RULE_02 RULE_03 RULE_04 RULE_05 RULE_06 RULE_07 RULE_08

	// target region against the protected window
	always_comb begin
		tgt = addr[fpd_pkg::DW-1:0] &
			(part_512k ? fpd_pkg::MASK_512K : fpd_pkg::MASK_256K);
		span   = span_of(opcode);
		reg_lo = tgt & ~span;
		reg_hi = reg_lo | span;
		hit    = !range_none && reg_lo <= range_hi && reg_hi >= range_lo;
	end

	// end-of-frame command execution, byte boundary only
	always_comb begin
		ready  = !busy && !suspended_flag;
		locked = sr_nv[fpd_pkg::SB_LOCK] && !sync2[3]; // RULE_15
		go_set = 1'b0;
		go_clr = 1'b0;
		go_status_write_cmd = 1'b0;
		go_start = 1'b0;
		go_susp = 1'b0;
		go_res = 1'b0;
		wr_cmd = 1'b0;
		if (frame_end && bitcnt == 3'h0) begin
			unique case (opcode)
				fpd_pkg::C_SET_WEL: go_set = ready && byteidx == fpd_pkg::LEN_CMD;
				fpd_pkg::C_CLR_WEL: go_clr = ready && byteidx == fpd_pkg::LEN_CMD;
				fpd_pkg::C_WR_SR: begin
					wr_cmd  = ready && byteidx >= fpd_pkg::LEN_STATUS_WRITE_CMD;
					go_status_write_cmd = wr_cmd && write_enable_latch && !locked; // RULE_11 RULE_15
				end
				fpd_pkg::C_PROG: begin
					wr_cmd   = ready && byteidx >= fpd_pkg::LEN_PROG;
					go_start = wr_cmd && write_enable_latch && !hit; // RULE_13
				end
				fpd_pkg::C_SECT, fpd_pkg::C_B32, fpd_pkg::C_B64: begin
					wr_cmd   = ready && byteidx == fpd_pkg::LEN_ADDR;
					go_start = wr_cmd && write_enable_latch && !hit; // RULE_13
				end
				fpd_pkg::C_CHIP_A, fpd_pkg::C_CHIP_B: begin
					wr_cmd   = ready && byteidx == fpd_pkg::LEN_CMD;
					go_start = wr_cmd && write_enable_latch && range_none; // RULE_13
				end
				fpd_pkg::C_SUSP: go_susp = busy && !suspended_flag &&
					byteidx == fpd_pkg::LEN_CMD &&
					op_kind_o != fpd_pkg::FPD_OP_STATUS;
				fpd_pkg::C_RESUME: go_res = suspended_flag &&
					byteidx == fpd_pkg::LEN_CMD;
				default: ;
			endcase
		end
	end

	// write enable latch
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			write_enable_latch <= 1'b0; // RULE_14
		end else if (go_set) begin
			write_enable_latch <= 1'b1; // RULE_14
		end else if (go_clr || wr_cmd) begin
			write_enable_latch <= 1'b0; // RULE_14
		end
	end

	// writable status bits; busy and latch never written
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sr_nv <= fpd_pkg::SR_RESET; // RULE_12
		end else if (go_status_write_cmd) begin
			sr_nv[7:0] <= sr_lo & fpd_pkg::SR_WR_MASK[7:0]; // RULE_16
			if (byteidx >= fpd_pkg::LEN_STATUS_WRITE_CMD_HI) begin
				sr_nv[15:8] <= sr_hi & fpd_pkg::SR_WR_MASK[15:8]; // RULE_16
			end
		end
	end

	// busy and suspend; a start wins over a done
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy           <= 1'b0;
			suspended_flag <= 1'b0;
		end else begin
			if (go_start || go_status_write_cmd) begin
				busy <= 1'b1; // RULE_10
			end else if (op_done_i) begin
				busy <= 1'b0; // RULE_10
			end
			if (go_susp) begin
				suspended_flag <= 1'b1;
			end else if (go_res) begin
				suspended_flag <= 1'b0;
			end
		end
	end

	// array operation requests
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			op_start_o   <= 1'b0;
			op_kind_o    <= fpd_pkg::FPD_OP_PROG;
			op_addr_o    <= '0;
			op_suspend_o <= 1'b0;
			op_resume_o  <= 1'b0;
		end else begin
			op_start_o   <= go_start || go_status_write_cmd;
			op_suspend_o <= go_susp;
			op_resume_o  <= go_res;
			if (go_start || go_status_write_cmd) begin
				op_kind_o <= kind_of(opcode);
				op_addr_o <= addr;
			end
		end
	end

	// program data forwarded only when the program will be taken
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prog_byte_o       <= '0;
			prog_byte_valid_o <= 1'b0;
		end else begin
			prog_byte_valid_o <= byte_done && opcode == fpd_pkg::C_PROG &&
				byteidx >= fpd_pkg::LEN_ADDR && ready &&
				write_enable_latch && !hit; // RULE_11 RULE_13
			if (byte_done) begin
				prog_byte_o <= new_byte;
			end
		end
	end
endmodule

/* core/fpd_range.sv */
// protect-select decoder: protected address window
`timescale 1ns/100ps
module fpd_range (
	// protection settings
	input  wire logic [4:0]             protect_sel_i,
	input  wire logic                   protect_complement_i,
	input  wire logic                   part_512k_i,
	// decoded window
	output logic                        range_none_o,
	output logic [fpd_pkg::DW-1:0]      range_lo_o,
	output logic [fpd_pkg::DW-1:0]      range_hi_o
);
	logic [7:0]  dens;
	logic [7:0]  units;
	logic        bottom;
	logic [19:0] lo_w;
	logic [19:0] hi_w;

	always_comb begin
		dens   = part_512k_i ? fpd_pkg::UNITS_512K : fpd_pkg::UNITS_256K;
		bottom = protect_sel_i[3];
		units  = fpd_pkg::U_NONE;
		if (protect_sel_i[4]) begin
			unique case (protect_sel_i[2:0])
				3'h0: units = fpd_pkg::U_NONE;
				3'h1: units = fpd_pkg::U_4K;
				3'h2: units = fpd_pkg::U_8K;
				3'h3: units = fpd_pkg::U_16K;
				3'h4, 3'h5, 3'h6: units = fpd_pkg::U_32K;
				3'h7: units = dens;
			endcase
		end else if (part_512k_i && protect_sel_i[2]) begin
			units = dens;
		end else begin
			unique case (protect_sel_i[1:0])
				2'h0: units = fpd_pkg::U_NONE;
				2'h1: units = fpd_pkg::U_64K;
				2'h2: units = fpd_pkg::U_128K;
				2'h3: units = part_512k_i ? fpd_pkg::U_256K : dens;
			endcase
		end
		// complemented window sits at the opposite end
		if (protect_complement_i) begin
			units  = dens - units;
			bottom = !bottom;
		end
		range_none_o = (units == fpd_pkg::U_NONE);
		if (bottom) begin
			lo_w = 20'h00000;
			hi_w = {units, 12'h000} - 20'h00001;
		end else begin
			lo_w = {8'(dens - units), 12'h000};
			hi_w = {dens, 12'h000} - 20'h00001;
		end
		range_lo_o = lo_w[fpd_pkg::DW-1:0];
		range_hi_o = hi_w[fpd_pkg::DW-1:0];
	end
endmodule

/* include/fpd_pkg.sv */
// constants and types for the flash array protection decoder
package fpd_pkg;
	localparam int AW = 24;
	localparam int DW = 19;
	localparam int UNIT_SHIFT = 12;
	localparam logic [DW-1:0] MASK_512K = 19'h7FFFF;
	localparam logic [DW-1:0] MASK_256K = 19'h3FFFF;
	// sizes counted in 4 KB units
	localparam logic [7:0] UNITS_512K = 8'h80;
	localparam logic [7:0] UNITS_256K = 8'h40;
	localparam logic [7:0] U_NONE = 8'h00;
	localparam logic [7:0] U_4K = 8'h01;
	localparam logic [7:0] U_8K = 8'h02;
	localparam logic [7:0] U_16K = 8'h04;
	localparam logic [7:0] U_32K = 8'h08;
	localparam logic [7:0] U_64K = 8'h10;
	localparam logic [7:0] U_128K = 8'h20;
	localparam logic [7:0] U_256K = 8'h40;
	// program and erase spans
	localparam logic [DW-1:0] SPAN_PAGE = 19'h00000;
	localparam logic [DW-1:0] SPAN_SECT = 19'h00FFF;
	localparam logic [DW-1:0] SPAN_B32 = 19'h07FFF;
	localparam logic [DW-1:0] SPAN_B64 = 19'h0FFFF;
	// status word layout
	localparam int SB_BUSY = 0;
	localparam int SB_WEL = 1;
	localparam int SB_BP = 2;
	localparam int SB_LOCK = 7;
	localparam int SB_QE = 9;
	localparam int SB_CMP = 14;
	localparam int SB_SUS = 15;
	localparam logic [15:0] SR_WR_MASK = 16'h42FC;
	localparam logic [15:0] SR_RESET = 16'h0000;
	// synchroniser idle: {strap, wp_n, si, cs_n, sclk}
	localparam logic [4:0] SYNC_RST = 5'h0E;
	// command codes
	localparam logic [7:0] C_SET_WEL = 8'h06;
	localparam logic [7:0] C_CLR_WEL = 8'h04;
	localparam logic [7:0] C_RD_LO = 8'h05;
	localparam logic [7:0] C_RD_HI = 8'h35;
	localparam logic [7:0] C_WR_SR = 8'h01;
	localparam logic [7:0] C_PROG = 8'h02;
	localparam logic [7:0] C_SECT = 8'h20;
	localparam logic [7:0] C_B32 = 8'h52;
	localparam logic [7:0] C_B64 = 8'hD8;
	localparam logic [7:0] C_CHIP_A = 8'h60;
	localparam logic [7:0] C_CHIP_B = 8'hC7;
	localparam logic [7:0] C_SUSP = 8'h75;
	localparam logic [7:0] C_RESUME = 8'h7A;
	// frame lengths in bytes
	localparam logic [2:0] LEN_CMD = 3'h1;
	localparam logic [2:0] LEN_STATUS_WRITE_CMD = 3'h2;
	localparam logic [2:0] LEN_STATUS_WRITE_CMD_HI = 3'h3;
	localparam logic [2:0] LEN_ADDR = 3'h4;
	localparam logic [2:0] LEN_PROG = 3'h5;
	localparam logic [2:0] LEN_MAX = 3'h7;
	localparam logic [2:0] BIT_LAST = 3'h7;
	typedef enum logic [2:0] {
		FPD_OP_PROG,
		FPD_OP_SECT,
		FPD_OP_B32,
		FPD_OP_B64,
		FPD_OP_CHIP,
		FPD_OP_STATUS
	} fpd_op_e;
endpackage

/* test/fpd_host.sv */
// serial host model: mode 0 frames, msb first
`timescale 1ns/100ps
module fpd_host (
	// clock
	input  logic sys_clk_i,
	// serial pins
	output logic sclk_o,
	output logic cs_n_o,
	output logic si_o,
	input  logic so_i
);
	localparam int H = 6;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end
	// nb whole bytes from the top of tx; rd keeps the last 8 bits seen
	task automatic frame(input logic [39:0] tx, input int nb,
		output logic [7:0] rd);
		logic [39:0] sh;
		sh = tx;
		rd = 8'h00;
		@(negedge sys_clk_i);
		cs_n_o = 1'b0;
		repeat (H) @(negedge sys_clk_i);
		for (int i = 0; i < nb * 8; i++) begin
			si_o = sh[39];
			sh = sh << 1;
			repeat (H) @(negedge sys_clk_i);
			rd = {rd[6:0], so_i};
			sclk_o = 1'b1;
			repeat (H) @(negedge sys_clk_i);
			sclk_o = 1'b0;
		end
		repeat (H) @(negedge sys_clk_i);
		cs_n_o = 1'b1;
		// released data line must not look like a held bit
		si_o = ~si_o;
		repeat (2 * H) @(negedge sys_clk_i);
	endtask
endmodule

/* test/fpd_props.sv */
// concurrent checks on the status word and array operation port
`timescale 1ns/100ps
module fpd_props (
	// clock and reset
	input logic                     sys_clk_i,
	input logic                     rst_n_i,
	// watched ports
	input logic                     cs_n_i,
	input logic                     so_oe_o,
	input logic                     op_start_o,
	input fpd_pkg::fpd_op_e         op_kind_o,
	input logic [fpd_pkg::AW-1:0]   op_addr_o,
	input logic                     op_done_i,
	input logic [15:0]              status_word_o,
	input logic                     quad_io_enable_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	start_clears_a: assert property (
		op_start_o |-> ##[0:1] status_word_o[1:0] == 2'h1)
		else $error("start left latch set or busy clear");
	reserved_zero_a: assert property (
		{status_word_o[13:10], status_word_o[8]} == 5'h00)
		else $error("reserved status bit set");
	start_latch_a: assert property (
		op_start_o |-> $past(status_word_o[1]))
		else $error("array op started without latch");
	start_idle_a: assert property (
		op_start_o |-> !$past(status_word_o[0]) && !$past(status_word_o[15]))
		else $error("array op started while busy");
	busy_fall_a: assert property (
		$fell(status_word_o[0]) |-> $past(op_done_i) || status_word_o[15])
		else $error("busy cleared with no array completion");
	quad_mirror_a: assert property (
		quad_io_enable_o == status_word_o[9])
		else $error("quad enable differs from status bit");
	op_hold_a: assert property (
		!op_start_o |-> $stable(op_kind_o) && $stable(op_addr_o))
		else $error("op kind or address moved without start");
	oe_release_a: assert property (
		$rose(cs_n_i) |-> ##[1:6] !so_oe_o)
		else $error("output enable held after deselect");
endmodule

/* test/tb.sv */
// self-checking bench for the status word and array protection core
`timescale 1ns/100ps
module tb;
	logic                   sys_clk_i;
	logic                   rst_n_i;
	logic                   sclk_i;
	logic                   cs_n_i;
	logic                   si_i;
	logic                   wp_n_i;
	logic                   so_o;
	logic                   so_oe_o;
	logic                   part_512k_i;
	logic                   op_start_o;
	fpd_pkg::fpd_op_e       op_kind_o;
	logic [fpd_pkg::AW-1:0] op_addr_o;
	logic                   op_done_i;
	logic                   op_suspend_o;
	logic                   op_resume_o;
	logic [7:0]             prog_byte_o;
	logic                   prog_byte_valid_o;
	logic [15:0]            status_word_o;
	logic                   quad_io_enable_o;
	logic [15:0]            w;
	logic [31:0]            e;
	int                     mismatches;
	int                     n_compared;
	int                     starts;
	int                     n_valid;
	int                     n_pause;
	int                     s0;
	// {chip, part, cmp, prot} bp[7:0] addr[19:0]
	logic [31:0] tbl [] = '{
		32'h7000_0000, 32'h6040_0000, 32'h61F7_F000,
		32'h7016_F000, 32'h6017_0000, 32'h6090_F000,
		32'h7091_0000, 32'h7033_F000, 32'h6034_0000,
		32'h7117_E000, 32'h6117_F000, 32'h6190_0000,
		32'h7190_1000, 32'h7167_7000, 32'h6167_8000,
		32'hC000_0000, 32'hF000_0000, 32'hD010_0000,
		32'h1013_0000, 32'h0012_F000, 32'h10A1_F000,
		32'h00A2_0000, 32'h1030_0000,
		32'h1113_F000, 32'h0113_E000, 32'h11B0_3000,
		32'h01B0_4000, 32'h0100_0000, 32'h1170_0000,
		32'h3012_F000, 32'h2013_0000, 32'h2030_0000,
		32'h3123_D000, 32'h2123_E000, 32'h3103_F000,
		32'h2170_0000,
		32'h2190_0000, 32'h3190_1000, 32'h21E0_7000,
		32'h31E0_8000
	};

	fpd_core u_fpd_core (.sys_clk_i, .rst_n_i, .sclk_i, .cs_n_i, .si_i,
		.wp_n_i, .so_o, .so_oe_o, .part_512k_i, .op_start_o, .op_kind_o,
		.op_addr_o, .op_done_i, .op_suspend_o, .op_resume_o, .prog_byte_o,
		.prog_byte_valid_o, .status_word_o, .quad_io_enable_o);
	fpd_host u_fpd_host (.sys_clk_i, .sclk_o(sclk_i), .cs_n_o(cs_n_i),
		.si_o(si_i), .so_i(so_o));

	initial begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		if (op_start_o === 1'b1)
			starts++;
		if (prog_byte_valid_o === 1'b1)
			n_valid++;
		if (op_suspend_o === 1'b1 || op_resume_o === 1'b1)
			n_pause++;
	end

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmd(logic [39:0] tx, int nb);
		logic [7:0] b;
		u_fpd_host.frame(tx, nb, b);
	endtask
	task automatic rd_sr(output logic [15:0] v);
		u_fpd_host.frame({8'h05, 32'h0}, 2, v[7:0]);
		u_fpd_host.frame({8'h35, 32'h0}, 2, v[15:8]);
	endtask
	task automatic wsr(logic [7:0] lo, logic [7:0] hi);
		cmd({8'h06, 32'h0}, 1);
		cmd({8'h01, lo, hi, 16'h0}, 3);
	endtask
	// array completes, then poll busy under a bound
	task automatic finish();
		logic [7:0] b;
		@(negedge sys_clk_i);
		op_done_i = 1'b1;
		@(negedge sys_clk_i);
		op_done_i = 1'b0;
		for (int k = 0; k < 4; k++) begin
			u_fpd_host.frame({8'h05, 32'h0}, 2, b);
			if (b[0] === 1'b0)
				return;
		end
		mismatches++;
		summarize();
	endtask
	task automatic reset_dut();
		rst_n_i = 1'b0;
		repeat (3) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge sys_clk_i);
	endtask

	initial begin
		rst_n_i = 1'b0;
		wp_n_i = 1'b1;
		part_512k_i = 1'b1;
		op_done_i = 1'b0;
		mismatches = 0;
		n_compared = 0;
		starts = 0;
		n_valid = 0;
		n_pause = 0;
		reset_dut();
		rd_sr(w);
		chk("status after reset", 24'h0, w);
		s0 = starts;
		cmd({8'h20, 32'h0}, 4);
		chk("erase without latch", 24'h0, 24'(starts - s0));
		cmd({8'h06, 32'h0}, 1);
		rd_sr(w);
		chk("latch after set", 24'h2, w);
		cmd({8'h04, 32'h0}, 1);
		rd_sr(w);
		chk("latch after clear", 24'h0, w);
		wsr(8'hFF, 8'hFF);
		chk("status op kind", 24'(fpd_pkg::FPD_OP_STATUS), 24'(op_kind_o));
		cmd({8'h06, 32'h0}, 1);
		rd_sr(w);
		chk("busy during write", 24'h1, w[1:0]);
		finish();
		rd_sr(w);
		chk("status readback", 24'h42FC, w);
		chk("quad enable", 24'h1, {23'h0, quad_io_enable_o});
		wp_n_i = 1'b0;
		s0 = starts;
		wsr(8'h00, 8'h00);
		chk("locked write", 24'h0, 24'(starts - s0));
		wp_n_i = 1'b1;
		wsr(8'h00, 8'h00);
		finish();
		rd_sr(w);
		chk("unlocked write", 24'h0, w);
		cmd({8'h06, 32'h0}, 1);
		s0 = starts;
		cmd({8'h02, 24'h012340, 8'hA5}, 5);
		chk("program start", 24'h1, 24'(starts - s0));
		chk("program kind", 24'(fpd_pkg::FPD_OP_PROG),
			24'(op_kind_o));
		chk("program address", 24'h012340, op_addr_o);
		chk("program data", 24'hA5, {16'h0, prog_byte_o});
		chk("program data valid", 24'h1, 24'(n_valid));
		cmd({8'h75, 32'h0}, 1);
		chk("suspend pulse", 24'h1, 24'(n_pause));
		rd_sr(w);
		chk("suspended status", 24'h8000, w);
		cmd({8'h7A, 32'h0}, 1);
		chk("resume pulse", 24'h2, 24'(n_pause));
		rd_sr(w);
		chk("resumed status", 24'h1, w);
		finish();
		cmd({8'h06, 32'h0}, 1);
		s0 = starts;
		cmd({8'hD8, 24'h054321, 8'h00}, 4);
		chk("block erase start", 24'h1, 24'(starts - s0));
		chk("block erase kind", 24'(fpd_pkg::FPD_OP_B64),
			24'(op_kind_o));
		finish();
		foreach (tbl[i]) begin
			e = tbl[i];
			if (e[30] !== part_512k_i) begin
				part_512k_i = e[30];
				reset_dut();
			end
			wsr({1'b0, e[24:20], 2'h0}, {1'b0, e[29], 6'h0});
			finish();
			s0 = starts;
			cmd({8'h06, 32'h0}, 1);
			if (e[31])
				cmd({e[29] ? 8'h60 : 8'hC7, 32'h0}, 1);
			else
				cmd({8'h20, 4'h0, e[19:0], 8'h0}, 4);
			chk("erase accepted", {23'h0, ~e[28]}, 24'(starts - s0));
			if (e[28] === 1'b0 && e[31] === 1'b0)
				chk("erase address", {4'h0, e[19:0]}, op_addr_o);
			if (e[28] === 1'b0)
				finish();
		end
		summarize();
	end
endmodule

bind fpd_core fpd_props u_fpd_props (.sys_clk_i, .rst_n_i, .cs_n_i,
	.so_oe_o, .op_start_o, .op_kind_o, .op_addr_o, .op_done_i,
	.status_word_o, .quad_io_enable_o);
